// ===== logic/rss_pkg.sv
// package: opcodes, flag layout, register map and timing for the rotate/subtract/skip datapath
package rss_pkg;
  // operation codes (values chosen for this block)
  typedef enum logic [4:0] {
    RSS_OP_NONE, RSS_OP_ROTATE_LEFT_TO_ACC, RSS_OP_ROTATE_LEFT_THRU_CARRY,
    RSS_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC, RSS_OP_ROTATE_RIGHT, RSS_OP_ROTATE_RIGHT_TO_ACC,
    RSS_OP_ROTATE_RIGHT_THRU_CARRY, RSS_OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC,
    RSS_OP_SUBTRACT_WITH_BORROW, RSS_OP_SUBTRACT_WITH_BORROW_TO_MEM, RSS_OP_SUBTRACT_PLAIN,
    RSS_OP_SUBTRACT_PLAIN_TO_MEM, RSS_OP_SUBTRACT_IMM, RSS_OP_DECREMENT_SKIP_ZERO,
    RSS_OP_DECREMENT_SKIP_ZERO_TO_ACC, RSS_OP_INCREMENT_SKIP_ZERO, RSS_OP_INCREMENT_SKIP_ZERO_TO_ACC,
    RSS_OP_SET_BYTE, RSS_OP_SET_BIT, RSS_OP_SKIP_BIT_NONZERO, RSS_OP_SKIP_ON_ZERO,
    RSS_OP_SKIP_ON_ZERO_COPY_ACC, RSS_OP_SKIP_BIT_ZERO, RSS_OP_NIBBLE_EXCHANGE,
    RSS_OP_NIBBLE_EXCHANGE_TO_ACC, RSS_OP_TABLE_READ_CURRENT_PAGE, RSS_OP_TABLE_READ_LAST_PAGE
  } rss_op_t;

  // flag bits in the flags register
  localparam int RSS_FLAG_C  = 0;
  localparam int RSS_FLAG_AC = 1;
  localparam int RSS_FLAG_Z  = 2;
  localparam int RSS_FLAG_OV = 3;

  // register byte addresses
  localparam logic [11:0] RSS_ADDR_CMD    = 12'h000;
  localparam logic [11:0] RSS_ADDR_ACC    = 12'h004;
  localparam logic [11:0] RSS_ADDR_MEM    = 12'h008;
  localparam logic [11:0] RSS_ADDR_FLAGS  = 12'h00c;
  localparam logic [11:0] RSS_ADDR_TPTR   = 12'h010;
  localparam logic [11:0] RSS_ADDR_TABLE_HIGH_LATCH   = 12'h014;
  localparam logic [11:0] RSS_ADDR_STATUS = 12'h018;
  localparam logic [11:0] RSS_ADDR_CODE   = 12'h01c;

  // command word fields
  localparam int RSS_CMD_OP_LSB  = 0;
  localparam int RSS_CMD_BIT_LSB = 8;
  localparam int RSS_CMD_IMM_LSB = 16;

  // reset values
  localparam logic [7:0]  RSS_RST_BYTE = 8'h00;
  localparam logic [3:0]  RSS_RST_FLAGS = 4'h0;
  localparam logic [15:0] RSS_RST_CODE = 16'h0000;

  // a skip takes two instruction cycles
  localparam logic [1:0] RSS_SKIP_CYCLES = 2'h2;

  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  mem;
    logic [3:0]  flags;
    logic [7:0]  tptr;
    logic [7:0]  table_high_latch;
    logic [15:0] code;
    logic        tpage;
    logic        skip;
    logic [1:0]  skip_cnt;
    logic [31:0] prdata;
  } rss_state_t;
endpackage

// ===== logic/rss_datapath.sv
// rotate/subtract/skip/table-read datapath with APB register access
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module rss_datapath (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // program code fetch
  output logic [7:0]       code_addr,
  output logic             code_page_last,
  input  wire logic [15:0] code_word,
  // sequencer
  output logic             skip_next
);
  rss_pkg::rss_state_t s_q;
  rss_pkg::rss_state_t s_d;

  logic             wr;
  logic             rd;
  rss_pkg::rss_op_t op;
  logic [2:0]       bsel;
  logic [7:0]       imm;
  logic [7:0]       m;
  logic             c;
  logic [7:0]       subtrahend;
  logic             borrow_in;
  logic [8:0]       diff;
  logic [4:0]       ldiff;
  logic [7:0]       inc;
  logic [7:0]       dec;
  logic             mapped;

  assign wr   = psel && penable && pwrite;
  assign rd   = psel && penable && !pwrite;
  assign op   = rss_pkg::rss_op_t'(pwdata[rss_pkg::RSS_CMD_OP_LSB +: 5]);
  assign bsel = pwdata[rss_pkg::RSS_CMD_BIT_LSB +: 3];
  assign imm  = pwdata[rss_pkg::RSS_CMD_IMM_LSB +: 8];
  assign m    = s_q.mem;
  assign c    = s_q.flags[rss_pkg::RSS_FLAG_C];
  assign inc  = m + 8'h01;
  assign dec  = m - 8'h01;

  always_comb begin
    subtrahend = (op == rss_pkg::RSS_OP_SUBTRACT_IMM) ? imm : m;
    borrow_in  = (op == rss_pkg::RSS_OP_SUBTRACT_WITH_BORROW ||
                  op == rss_pkg::RSS_OP_SUBTRACT_WITH_BORROW_TO_MEM) ? !c : 1'b0;
    diff  = {1'b0, s_q.acc} - {1'b0, subtrahend} - {8'h00, borrow_in};
    ldiff = {1'b0, s_q.acc[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
  end

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      rss_pkg::RSS_ADDR_CMD, rss_pkg::RSS_ADDR_ACC, rss_pkg::RSS_ADDR_MEM, rss_pkg::RSS_ADDR_FLAGS,
      rss_pkg::RSS_ADDR_TPTR, rss_pkg::RSS_ADDR_TABLE_HIGH_LATCH, rss_pkg::RSS_ADDR_STATUS,
      rss_pkg::RSS_ADDR_CODE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // a pending skip burns a second instruction cycle before it is released
    if (s_q.skip_cnt != 2'h0) begin
      s_d.skip_cnt = s_q.skip_cnt - 2'h1;
      if (s_q.skip_cnt == 2'h1) begin
        s_d.skip = 1'b0;
      end
    end
    if (rd) begin
      unique case (paddr)
        rss_pkg::RSS_ADDR_ACC:    s_d.prdata = {24'h0, s_q.acc};
        rss_pkg::RSS_ADDR_MEM:    s_d.prdata = {24'h0, s_q.mem};
        rss_pkg::RSS_ADDR_FLAGS:  s_d.prdata = {28'h0, s_q.flags};
        rss_pkg::RSS_ADDR_TPTR:   s_d.prdata = {23'h0, s_q.tpage, s_q.tptr};
        rss_pkg::RSS_ADDR_TABLE_HIGH_LATCH:   s_d.prdata = {24'h0, s_q.table_high_latch};
        rss_pkg::RSS_ADDR_STATUS: s_d.prdata = {30'h0, s_q.skip_cnt != 2'h0, s_q.skip};
        rss_pkg::RSS_ADDR_CODE:   s_d.prdata = {16'h0, s_q.code};
        default:                  s_d.prdata = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        rss_pkg::RSS_ADDR_ACC:   s_d.acc   = pwdata[7:0];
        rss_pkg::RSS_ADDR_MEM:   s_d.mem   = pwdata[7:0];
        rss_pkg::RSS_ADDR_FLAGS: s_d.flags = pwdata[3:0];
        rss_pkg::RSS_ADDR_TPTR: begin
          s_d.tptr  = pwdata[7:0];
          s_d.tpage = pwdata[8];
        end
        rss_pkg::RSS_ADDR_CMD: begin
          unique case (op)
            rss_pkg::RSS_OP_ROTATE_LEFT_TO_ACC: s_d.acc = {m[6:0], m[7]};
            rss_pkg::RSS_OP_ROTATE_LEFT_THRU_CARRY: begin
              s_d.mem = {m[6:0], c};
              s_d.flags[rss_pkg::RSS_FLAG_C] = m[7];
            end
            rss_pkg::RSS_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
              s_d.acc = {m[6:0], c};
              s_d.flags[rss_pkg::RSS_FLAG_C] = m[7];
            end
            rss_pkg::RSS_OP_ROTATE_RIGHT:        s_d.mem = {m[0], m[7:1]};
            rss_pkg::RSS_OP_ROTATE_RIGHT_TO_ACC: s_d.acc = {m[0], m[7:1]};
            rss_pkg::RSS_OP_ROTATE_RIGHT_THRU_CARRY: begin
              s_d.mem = {c, m[7:1]};
              s_d.flags[rss_pkg::RSS_FLAG_C] = m[0];
            end
            rss_pkg::RSS_OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
              s_d.acc = {c, m[7:1]};
              s_d.flags[rss_pkg::RSS_FLAG_C] = m[0];
            end
            rss_pkg::RSS_OP_SUBTRACT_WITH_BORROW, rss_pkg::RSS_OP_SUBTRACT_WITH_BORROW_TO_MEM,
            rss_pkg::RSS_OP_SUBTRACT_PLAIN, rss_pkg::RSS_OP_SUBTRACT_PLAIN_TO_MEM,
            rss_pkg::RSS_OP_SUBTRACT_IMM: begin
              if (op == rss_pkg::RSS_OP_SUBTRACT_WITH_BORROW_TO_MEM ||
                  op == rss_pkg::RSS_OP_SUBTRACT_PLAIN_TO_MEM) begin
                s_d.mem = diff[7:0];
              end else begin
                s_d.acc = diff[7:0];
              end
              // carry means no borrow out of bit 7
              s_d.flags[rss_pkg::RSS_FLAG_C]  = !diff[8];
              s_d.flags[rss_pkg::RSS_FLAG_AC] = !ldiff[4];
              s_d.flags[rss_pkg::RSS_FLAG_Z]  = (diff[7:0] == 8'h00);
              s_d.flags[rss_pkg::RSS_FLAG_OV] = (s_q.acc[7] != subtrahend[7]) &&
                                                (diff[7] != s_q.acc[7]);
            end
            rss_pkg::RSS_OP_DECREMENT_SKIP_ZERO: begin
              s_d.mem  = dec;
              s_d.skip = (dec == 8'h00);
            end
            rss_pkg::RSS_OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
              s_d.acc  = dec;
              s_d.skip = (dec == 8'h00);
            end
            rss_pkg::RSS_OP_INCREMENT_SKIP_ZERO: begin
              s_d.mem  = inc;
              s_d.skip = (inc == 8'h00);
            end
            rss_pkg::RSS_OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
              s_d.acc  = inc;
              s_d.skip = (inc == 8'h00);
            end
            rss_pkg::RSS_OP_SET_BYTE:         s_d.mem = 8'hff;
            rss_pkg::RSS_OP_SET_BIT:          s_d.mem[bsel] = 1'b1;
            rss_pkg::RSS_OP_SKIP_BIT_NONZERO: s_d.skip = m[bsel];
            rss_pkg::RSS_OP_SKIP_ON_ZERO:     s_d.skip = (m == 8'h00);
            rss_pkg::RSS_OP_SKIP_ON_ZERO_COPY_ACC: begin
              s_d.acc  = m;
              s_d.skip = (m == 8'h00);
            end
            rss_pkg::RSS_OP_SKIP_BIT_ZERO:         s_d.skip = !m[bsel];
            rss_pkg::RSS_OP_NIBBLE_EXCHANGE:       s_d.mem = {m[3:0], m[7:4]};
            rss_pkg::RSS_OP_NIBBLE_EXCHANGE_TO_ACC: s_d.acc = {m[3:0], m[7:4]};
            rss_pkg::RSS_OP_TABLE_READ_CURRENT_PAGE, rss_pkg::RSS_OP_TABLE_READ_LAST_PAGE: begin
              // code word is sampled combinationally in the access cycle
              s_d.mem  = code_word[7:0];
              s_d.table_high_latch = code_word[15:8];
              s_d.code = code_word;
            end
            default: s_d.mem = s_q.mem;
          endcase
          if (op inside {rss_pkg::RSS_OP_DECREMENT_SKIP_ZERO, rss_pkg::RSS_OP_DECREMENT_SKIP_ZERO_TO_ACC,
                         rss_pkg::RSS_OP_INCREMENT_SKIP_ZERO, rss_pkg::RSS_OP_INCREMENT_SKIP_ZERO_TO_ACC,
                         rss_pkg::RSS_OP_SKIP_BIT_NONZERO, rss_pkg::RSS_OP_SKIP_ON_ZERO,
                         rss_pkg::RSS_OP_SKIP_ON_ZERO_COPY_ACC, rss_pkg::RSS_OP_SKIP_BIT_ZERO}) begin
            s_d.skip_cnt = rss_pkg::RSS_SKIP_CYCLES;
          end
        end
        default: s_d.acc = s_q.acc;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.acc      <= rss_pkg::RSS_RST_BYTE;
      s_q.mem      <= rss_pkg::RSS_RST_BYTE;
      s_q.flags    <= rss_pkg::RSS_RST_FLAGS;
      s_q.tptr     <= rss_pkg::RSS_RST_BYTE;
      s_q.table_high_latch     <= rss_pkg::RSS_RST_BYTE;
      s_q.code     <= rss_pkg::RSS_RST_CODE;
      s_q.tpage    <= 1'b0;
      s_q.skip     <= 1'b0;
      s_q.skip_cnt <= 2'h0;
      s_q.prdata   <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // read data comes straight from the state flops, so there are no wait states
  assign pready         = 1'b1;
  assign pslverr        = psel && penable && !mapped;
  assign prdata         = rd ? read_now(paddr) : 32'h0;
  assign code_addr      = s_q.tptr;
  assign code_page_last = (wr && paddr == rss_pkg::RSS_ADDR_CMD) ?
                          (op == rss_pkg::RSS_OP_TABLE_READ_LAST_PAGE) : s_q.tpage;
  assign skip_next      = s_q.skip;

  function automatic logic [31:0] read_now(input logic [11:0] a);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      rss_pkg::RSS_ADDR_ACC:    r = {24'h0, s_q.acc};
      rss_pkg::RSS_ADDR_MEM:    r = {24'h0, s_q.mem};
      rss_pkg::RSS_ADDR_FLAGS:  r = {28'h0, s_q.flags};
      rss_pkg::RSS_ADDR_TPTR:   r = {23'h0, s_q.tpage, s_q.tptr};
      rss_pkg::RSS_ADDR_TABLE_HIGH_LATCH:   r = {24'h0, s_q.table_high_latch};
      rss_pkg::RSS_ADDR_STATUS: r = {30'h0, s_q.skip_cnt != 2'h0, s_q.skip};
      rss_pkg::RSS_ADDR_CODE:   r = {16'h0, s_q.code};
      default:                  r = 32'h0;
    endcase
    return r;
  endfunction
endmodule

// ===== sim/rss_datapath_asserts.sv
// assertion checker for the bus, code fetch and skip ports of the datapath
`timescale 1ns/1ps
module rss_datapath_asserts (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // code fetch and sequencer
  input wire logic [7:0]  code_addr,
  input wire logic        code_page_last,
  input wire logic [15:0] code_word,
  input wire logic        skip_next
);
  logic acc_ph;
  logic cmd_wr;
  assign acc_ph = psel && penable;
  assign cmd_wr = acc_ph && pwrite && paddr == rss_pkg::RSS_ADDR_CMD;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_always_a: assert property (psel |-> ##1 pready) else $error("ready low");
  unmapped_err_a: assert property (acc_ph && paddr > 12'h01c |-> pslverr) else $error("no error on unmapped");
  mapped_ok_a: assert property (acc_ph && paddr <= 12'h01c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped");
  rdata_idle_a: assert property (!(acc_ph && !pwrite) |-> prdata == 32'h0) else $error("read data outside read");
  unmapped_zero_a: assert property (acc_ph && !pwrite && pslverr |-> prdata == 32'h0) else $error("unmapped data");
  skip_hold_a: assert property ($rose(skip_next) |=> skip_next) else $error("skip too short");
  skip_cause_a: assert property ($rose(skip_next) |-> $past(cmd_wr)) else $error("skip without command");
  skip_end_a: assert property ($past(cmd_wr, 2) && !$past(cmd_wr) && !cmd_wr |=> !skip_next)
    else $error("skip too long");
  page_last_a: assert property (cmd_wr && pwdata[4:0] == rss_pkg::RSS_OP_TABLE_READ_LAST_PAGE
    |-> code_page_last) else $error("last page not selected");
  tptr_addr_a: assert property (!$stable(code_addr) |->
    $past(acc_ph && pwrite && paddr == rss_pkg::RSS_ADDR_TPTR)) else $error("pointer moved");
  cover property ($rose(skip_next));
  cover property (cmd_wr && pwdata[4:0] == rss_pkg::RSS_OP_TABLE_READ_LAST_PAGE);
  cover property (acc_ph && pslverr);
endmodule
bind rss_datapath rss_datapath_asserts rss_datapath_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .code_addr(code_addr), .code_page_last(code_page_last), .code_word(code_word),
  .skip_next(skip_next));

// ===== sim/tb_rss_datapath.sv
// self-checking bench for the rotate/subtract/skip datapath
`timescale 1ns/1ps
module tb_rss_datapath;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        code_page_last;
  logic        skip_next;
  logic [7:0]  code_addr;
  logic [15:0] code_word;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  always #4 pclk = ~pclk;
  // code store stand-in: the word depends on pointer and page, so a wrong page shows
  assign code_word = {code_addr ^ {code_page_last, 7'h2a}, ~code_addr};
  rss_datapath rss_datapath_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .code_addr(code_addr), .code_page_last(code_page_last), .code_word(code_word), .skip_next(skip_next));
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // a hung handshake ends the run here
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      failures++;
      test_done();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request is held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  // load operands, issue one command, then judge skip timing and the three results
  task automatic run(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] imm, input logic [7:0] a0,
                     input logic [7:0] m0, input logic [3:0] f0, input logic [7:0] ea, input logic [7:0] em,
                     input logic [3:0] ef, input logic es);
    logic [31:0] a;
    logic [31:0] m;
    logic [31:0] f;
    logic [2:0]  s;
    wr(rss_pkg::RSS_ADDR_ACC, {24'h0, a0});
    wr(rss_pkg::RSS_ADDR_MEM, {24'h0, m0});
    wr(rss_pkg::RSS_ADDR_FLAGS, {28'h0, f0});
    wr(rss_pkg::RSS_ADDR_CMD, {8'h00, imm, 5'h00, bs, 3'h0, op});
    @(negedge pclk) s[2] = skip_next;
    @(negedge pclk) s[1] = skip_next;
    @(negedge pclk) s[0] = skip_next;
    rd(rss_pkg::RSS_ADDR_ACC, a);
    rd(rss_pkg::RSS_ADDR_MEM, m);
    rd(rss_pkg::RSS_ADDR_FLAGS, f);
    cmp({a[7:0], m[7:0], f[3:0], s}, {ea, em, ef, es, es, 1'b0});
  endtask
  task automatic test_bus();
    logic [31:0] q;
    logic        e;
    rd(rss_pkg::RSS_ADDR_FLAGS, q);
    cmp(q, 32'h0);
    apb(1'b0, 12'h020, 32'h0, q, e);
    cmp(q, 32'h0);
    cmp({31'h0, e}, 32'h1);
    apb(1'b1, 12'h020, 32'h0, q, e);
    cmp({31'h0, e}, 32'h1);
    $display("test bus done");
  endtask
  task automatic test_rotate();
    run(5'h01, 3'h0, 8'h00, 8'h00, 8'h96, 4'hb, 8'h2d, 8'h96, 4'hb, 1'b0);
    run(5'h02, 3'h0, 8'h00, 8'h00, 8'h96, 4'h0, 8'h00, 8'h2c, 4'h1, 1'b0);
    run(5'h03, 3'h0, 8'h00, 8'h00, 8'h16, 4'h1, 8'h2d, 8'h16, 4'h0, 1'b0);
    run(5'h04, 3'h0, 8'h00, 8'h00, 8'h96, 4'h6, 8'h00, 8'h4b, 4'h6, 1'b0);
    run(5'h05, 3'h0, 8'h00, 8'h00, 8'h97, 4'h0, 8'hcb, 8'h97, 4'h0, 1'b0);
    run(5'h06, 3'h0, 8'h00, 8'h00, 8'h96, 4'h1, 8'h00, 8'hcb, 4'h0, 1'b0);
    run(5'h07, 3'h0, 8'h00, 8'h00, 8'h01, 4'h0, 8'h00, 8'h01, 4'h1, 1'b0);
    $display("test rotate done");
  endtask
  task automatic test_subtract();
    run(5'h08, 3'h0, 8'h00, 8'h50, 8'h70, 4'h1, 8'he0, 8'h70, 4'h2, 1'b0);
    run(5'h08, 3'h0, 8'h00, 8'h10, 8'h0f, 4'h0, 8'h00, 8'h0f, 4'h5, 1'b0);
    run(5'h09, 3'h0, 8'h00, 8'h80, 8'h01, 4'h1, 8'h80, 8'h7f, 4'h9, 1'b0);
    run(5'h0a, 3'h0, 8'h00, 8'h05, 8'h05, 4'h0, 8'h00, 8'h05, 4'h7, 1'b0);
    run(5'h0b, 3'h0, 8'h00, 8'h00, 8'h01, 4'hf, 8'h00, 8'hff, 4'h0, 1'b0);
    run(5'h0c, 3'h0, 8'h21, 8'h20, 8'h00, 4'hf, 8'hff, 8'h00, 4'h0, 1'b0);
    $display("test subtract done");
  endtask
  task automatic test_skip();
    run(5'h0d, 3'h0, 8'h00, 8'h00, 8'h01, 4'ha, 8'h00, 8'h00, 4'ha, 1'b1);
    run(5'h0d, 3'h0, 8'h00, 8'h00, 8'h00, 4'ha, 8'h00, 8'hff, 4'ha, 1'b0);
    run(5'h0e, 3'h0, 8'h00, 8'h55, 8'h01, 4'ha, 8'h00, 8'h01, 4'ha, 1'b1);
    run(5'h0f, 3'h0, 8'h00, 8'h00, 8'hff, 4'ha, 8'h00, 8'h00, 4'ha, 1'b1);
    run(5'h10, 3'h0, 8'h00, 8'h55, 8'hfe, 4'ha, 8'hff, 8'hfe, 4'ha, 1'b0);
    run(5'h13, 3'h3, 8'h00, 8'h00, 8'h08, 4'ha, 8'h00, 8'h08, 4'ha, 1'b1);
    run(5'h13, 3'h3, 8'h00, 8'h00, 8'hf7, 4'ha, 8'h00, 8'hf7, 4'ha, 1'b0);
    run(5'h14, 3'h0, 8'h00, 8'h00, 8'h00, 4'ha, 8'h00, 8'h00, 4'ha, 1'b1);
    run(5'h14, 3'h0, 8'h00, 8'h00, 8'h01, 4'ha, 8'h00, 8'h01, 4'ha, 1'b0);
    run(5'h15, 3'h0, 8'h00, 8'h33, 8'h00, 4'ha, 8'h00, 8'h00, 4'ha, 1'b1);
    run(5'h15, 3'h0, 8'h00, 8'h33, 8'h5a, 4'ha, 8'h5a, 8'h5a, 4'ha, 1'b0);
    run(5'h16, 3'h3, 8'h00, 8'h00, 8'hf7, 4'ha, 8'h00, 8'hf7, 4'ha, 1'b1);
    run(5'h16, 3'h3, 8'h00, 8'h00, 8'h08, 4'ha, 8'h00, 8'h08, 4'ha, 1'b0);
    $display("test skip done");
  endtask
  task automatic test_bits_table();
    logic [31:0] q;
    run(5'h11, 3'h0, 8'h00, 8'h00, 8'h00, 4'h5, 8'h00, 8'hff, 4'h5, 1'b0);
    run(5'h12, 3'h7, 8'h00, 8'h00, 8'h00, 4'h5, 8'h00, 8'h80, 4'h5, 1'b0);
    run(5'h12, 3'h0, 8'h00, 8'h00, 8'h10, 4'h5, 8'h00, 8'h11, 4'h5, 1'b0);
    run(5'h17, 3'h0, 8'h00, 8'h00, 8'h3c, 4'h5, 8'h00, 8'hc3, 4'h5, 1'b0);
    run(5'h18, 3'h0, 8'h00, 8'h00, 8'ha5, 4'h5, 8'h5a, 8'ha5, 4'h5, 1'b0);
    wr(rss_pkg::RSS_ADDR_TPTR, 32'h0000003c);
    run(5'h19, 3'h0, 8'h00, 8'h00, 8'h00, 4'h5, 8'h00, 8'hc3, 4'h5, 1'b0);
    rd(rss_pkg::RSS_ADDR_TABLE_HIGH_LATCH, q);
    cmp(q, 32'h16);
    run(5'h1a, 3'h0, 8'h00, 8'h00, 8'h00, 4'h5, 8'h00, 8'hc3, 4'h5, 1'b0);
    wr(rss_pkg::RSS_ADDR_TABLE_HIGH_LATCH, 32'hff);
    rd(rss_pkg::RSS_ADDR_TABLE_HIGH_LATCH, q);
    cmp(q, 32'h96);
    rd(rss_pkg::RSS_ADDR_CODE, q);
    cmp(q, 32'h96c3);
    $display("test bits and table done");
  endtask
  // reset in mid-run must clear the accumulator, the pointer and the code word
  task automatic test_reset();
    logic [31:0] q;
    wr(rss_pkg::RSS_ADDR_ACC, 32'h5a);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(rss_pkg::RSS_ADDR_ACC, q);
    cmp(q, 32'h0);
    rd(rss_pkg::RSS_ADDR_TPTR, q);
    cmp(q, 32'h0);
    rd(rss_pkg::RSS_ADDR_CODE, q);
    cmp(q, 32'h0);
    $display("test reset done");
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    test_bus();
    test_rotate();
    test_subtract();
    test_skip();
    test_bits_table();
    test_reset();
    test_done();
  end
endmodule
